// ---- rtl/arp_pkg.sv ----
package arp_pkg;
	localparam int RES_BITS = 18;
	localparam int ADDR_W = 4;

	localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_CFG = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_RESULT = 4'hC;

	localparam int CTRL_W = 10;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_CODING = 2;
	localparam int CTRL_CLKSRC = 3;
	localparam int CTRL_SCLK_INV = 4;
	localparam int CTRL_SYNC_INV = 5;
	localparam int CTRL_RDC = 6;
	localparam int CTRL_DIV_LSB = 7;
	localparam int CTRL_PD = 9;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;

	localparam int CFG_W = 2;
	localparam int CFG_CODING = 0;
	localparam int CFG_PD = 1;
	localparam logic [CFG_W-1:0] CFG_RESET = 2'h0;

	localparam int STAT_BUSY = 0;
	localparam int STAT_CONV = 1;
	localparam int STAT_SHIFT = 2;
	localparam int STAT_RESET_PIN = 3;

	typedef enum logic [1:0] {
		MODE_P18 = 2'h0,
		MODE_P16 = 2'h1,
		MODE_P8 = 2'h2,
		MODE_SER = 2'h3
	} arp_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_SHIFT = 2'b11
	} arp_conv_t;

	localparam int PIN_MS_OUT = 10;
	localparam int PIN_MS_CLK = 11;
	localparam int PIN_MS_SYNC = 12;
	localparam int PIN_SS_OUT = 8;
	localparam int PIN_SS_ERR = 13;

	localparam int BIT_CNT_W = 5;
	localparam logic [BIT_CNT_W-1:0] BITS_DONE = 5'h12;
	localparam logic [BIT_CNT_W-1:0] FAST_BITS = 5'h0C;
	localparam logic [3:0] FAST_HALF = 4'h2;
	localparam logic [3:0] SLOW_HALF = 4'h3;
	localparam logic [3:0] DIV_HALF_BASE = 4'h1;

	localparam int CLK_PERIOD_NS = 10;
	localparam int T_CONV_NS = 1000;
	localparam int CONV_CYCLES = (T_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MIN_CONV_CYCLES = 90;
	localparam int CNT_W = 8;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- rtl/arp_readout.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Deselect or read high tristates all data outputs
// - Reset pin high aborts conversion, tristates bus
// - Reset pin fall clears bus and configuration
// - Mode 0/1/2 selects 18/16/8-bit bus
// - Parallel modes drive the latest result only while selected
// - Full 18-bit bus always straight binary
// - Other modes honour coding select
// - Word selects pick two words or three bytes
// - Mode 3 puts serial on upper pins
// - Eighteen bits out MSB first, one per clock
// - Configuration register writable only in serial mode
// - Master pins 12..10, slave pins 13 and 8
// - Internal clock source drives clock and sync
// - Invert inputs flip clock and sync polarity
// - Master read-during: previous result, two periods
// - Master read-after keeps busy until shifted
// - Divider sets read-after clock period
// - External clock shifts only while selected
// - External clock may idle high or low
// - Started conversion completes despite power-down
// - Slave read-during underrun pulses read overrun
module arp_readout #(
	parameter int CONV_LEN = arp_pkg::CONV_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [arp_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [arp_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic cs_n_pin,
	input wire logic rd_n_pin,
	input wire logic reset_pin,
	input wire logic convert_start_n,
	input wire logic word_select_lo,
	input wire logic word_select_hi,
	input wire logic serial_shift_clock,
	input wire logic [arp_pkg::RES_BITS-1:0] conv_result,
	output logic [arp_pkg::RES_BITS-1:0] data_out,
	output logic [arp_pkg::RES_BITS-1:0] data_oe,
	output logic busy
);
	import arp_pkg::*;

	if (CONV_LEN < MIN_CONV_CYCLES || CONV_LEN > 255) begin : g_bad_conv_len
		$error("CONV_LEN must allow a full shift-out and fit the counter");
	end

	typedef struct packed {
		logic cs_m, cs_s, rd_m, rd_s;
		logic cnv_m, cnv_s, cnv_d;
		logic rst_m, rst_s, rst_d;
		logic [1:0] ws_m, ws_s;
		logic clk_m, clk_s, clk_d;
		logic [CTRL_W-1:0] ctrl;
		logic [CFG_W-1:0] cfg;
		arp_conv_t st;
		logic [CNT_W-1:0] conv_cnt;
		logic busy;
		logic [RES_BITS-1:0] result;
		logic [RES_BITS-1:0] sh;
		logic [BIT_CNT_W-1:0] bit_cnt;
		logic [3:0] half_cnt;
		logic sclk;
		logic overrun;
		logic [RES_BITS-1:0] dout, doe;
		logic aw_held, w_held;
		logic [ADDR_W-1:0] aw_addr;
		logic [31:0] wdat;
		logic [3:0] wstr;
		logic awready, wready, bvalid, arready, rvalid;
		logic [1:0] bresp, rresp;
		logic [31:0] rdata;
	} arp_state_t;

	function automatic arp_state_t init_state();
		arp_state_t r;
		r = '0;
		r.cs_m = 1'b1;
		r.cs_s = 1'b1;
		r.rd_m = 1'b1;
		r.rd_s = 1'b1;
		r.cnv_m = 1'b1;
		r.cnv_s = 1'b1;
		r.cnv_d = 1'b1;
		r.ctrl = CTRL_RESET;
		r.cfg = CFG_RESET;
		r.st = ST_IDLE;
		r.bit_cnt = BITS_DONE;
		return r;
	endfunction

	function automatic logic [RES_BITS-1:0] encode(input logic [RES_BITS-1:0] r, input logic straight);
		return straight ? r : {~r[RES_BITS-1], r[RES_BITS-2:0]};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return m;
	endfunction

	localparam arp_state_t RESET_STATE = init_state();

	arp_state_t s, next_s;
	arp_mode_t mode;
	logic serial, master_ser, slave_ser, read_during_conv, straight, selected, start, pd, conv_done;
	logic master_active, slave_edge, rst_fall;
	logic [3:0] half;
	logic [RES_BITS-1:0] coded;
	logic [31:0] wmerged;

	always_comb begin
		next_s = s;
		wmerged = 32'h0000_0000;
		// Pin inputs pass two flops before any logic reads them
		next_s.cs_m = cs_n_pin;
		next_s.cs_s = s.cs_m;
		next_s.rd_m = rd_n_pin;
		next_s.rd_s = s.rd_m;
		next_s.cnv_m = convert_start_n;
		next_s.cnv_s = s.cnv_m;
		next_s.cnv_d = s.cnv_s;
		next_s.rst_m = reset_pin;
		next_s.rst_s = s.rst_m;
		next_s.rst_d = s.rst_s;
		next_s.ws_m = {word_select_hi, word_select_lo};
		next_s.ws_s = s.ws_m;
		next_s.clk_m = serial_shift_clock;
		next_s.clk_s = s.clk_m;
		next_s.clk_d = s.clk_s;

		mode = arp_mode_t'(s.ctrl[CTRL_MODE_LSB +: 2]);
		serial = (mode == MODE_SER);
		master_ser = serial && !s.ctrl[CTRL_CLKSRC];
		slave_ser = serial && s.ctrl[CTRL_CLKSRC];
		read_during_conv = s.ctrl[CTRL_RDC];
		straight = (mode == MODE_P18) || (serial ? s.cfg[CFG_CODING] : s.ctrl[CTRL_CODING]);
		coded = encode(s.result, straight);
		selected = !s.cs_s && !s.rd_s && !s.rst_s;
		start = s.cnv_d && !s.cnv_s;
		rst_fall = s.rst_d && !s.rst_s;
		pd = serial ? s.cfg[CFG_PD] : s.ctrl[CTRL_PD];
		if (read_during_conv) begin
			half = (s.bit_cnt < FAST_BITS) ? FAST_HALF : SLOW_HALF;
		end else begin
			half = 4'(DIV_HALF_BASE << s.ctrl[CTRL_DIV_LSB +: 2]);
		end
		master_active = master_ser && (s.bit_cnt != BITS_DONE) &&
			((s.st == ST_CONV && read_during_conv) || s.st == ST_SHIFT);
		// Either idle level works: only the edge toward the active level shifts
		slave_edge = (s.clk_s ^ s.clk_d) && (s.clk_s ^ s.ctrl[CTRL_SCLK_INV]);
		conv_done = 1'b0;
		next_s.overrun = 1'b0;

		// Shift engines
		if (master_active) begin
			if (s.half_cnt == 4'h0) begin
				next_s.half_cnt = half - 4'h1;
				next_s.sclk = ~s.sclk;
				if (s.sclk) begin
					next_s.sh = {s.sh[RES_BITS-2:0], 1'b0};
					next_s.bit_cnt = s.bit_cnt + 5'h01;
				end
			end else begin
				next_s.half_cnt = s.half_cnt - 4'h1;
			end
		end else if (slave_ser && selected && slave_edge && s.bit_cnt != BITS_DONE) begin
			next_s.sh = {s.sh[RES_BITS-2:0], 1'b0};
			next_s.bit_cnt = s.bit_cnt + 5'h01;
		end

		unique case (s.st)
			ST_IDLE: begin
				// Power-down only blocks new starts; a running conversion finishes
				if (start && !pd) begin
					next_s.st = ST_CONV;
					next_s.conv_cnt = CNT_W'(CONV_LEN - 1);
					next_s.busy = 1'b1;
					if (master_ser && read_during_conv) begin
						next_s.sh = coded;
						next_s.bit_cnt = '0;
						next_s.half_cnt = half - 4'h1;
						next_s.sclk = 1'b0;
					end
				end
			end
			ST_CONV: begin
				if (s.conv_cnt == '0) begin
					conv_done = 1'b1;
				end else begin
					next_s.conv_cnt = s.conv_cnt - 8'h01;
				end
			end
			ST_SHIFT: begin
				// The shift engine stops at the last bit; the final low half is timed out here
				if (s.bit_cnt == BITS_DONE) begin
					if (s.half_cnt == 4'h0) begin
						next_s.st = ST_IDLE;
						next_s.busy = 1'b0;
					end else begin
						next_s.half_cnt = s.half_cnt - 4'h1;
					end
				end
			end
			default: begin
				next_s.st = ST_IDLE;
			end
		endcase

		if (conv_done) begin
			next_s.result = conv_result;
			if (slave_ser && read_during_conv && s.bit_cnt != BITS_DONE) begin
				next_s.overrun = 1'b1;
			end
			if (serial) begin
				next_s.sh = encode(conv_result, straight);
				next_s.bit_cnt = '0;
				next_s.half_cnt = half - 4'h1;
				next_s.sclk = 1'b0;
			end
			if (master_ser && !read_during_conv) begin
				next_s.st = ST_SHIFT;
			end else begin
				next_s.st = ST_IDLE;
				next_s.busy = 1'b0;
				if (master_ser) begin
					next_s.bit_cnt = BITS_DONE;
				end
			end
		end

		// Register bus: address and data accepted in either order
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.awready && awvalid) begin
			next_s.aw_held = 1'b1;
			next_s.aw_addr = awaddr;
		end
		if (s.wready && wvalid) begin
			next_s.w_held = 1'b1;
			next_s.wdat = wdata;
			next_s.wstr = wstrb;
		end
		if (s.aw_held && s.w_held && !s.bvalid) begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			unique case (s.aw_addr)
				OFF_CTRL: begin
					wmerged = merge(32'(s.ctrl), s.wdat, s.wstr);
					next_s.ctrl = wmerged[CTRL_W-1:0];
				end
				OFF_CFG: begin
					if (serial) begin
						wmerged = merge(32'(s.cfg), s.wdat, s.wstr);
						next_s.cfg = wmerged[CFG_W-1:0];
					end else begin
						next_s.bresp = RESP_SLVERR;
					end
				end
				default: begin
					next_s.bresp = RESP_SLVERR;
				end
			endcase
		end
		next_s.awready = !next_s.aw_held && !next_s.bvalid;
		next_s.wready = !next_s.w_held && !next_s.bvalid;
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s.arready && arvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			unique case (araddr)
				OFF_CTRL: next_s.rdata = 32'(s.ctrl);
				OFF_CFG: next_s.rdata = 32'(s.cfg);
				OFF_STATUS: begin
					next_s.rdata = 32'h0000_0000;
					next_s.rdata[STAT_BUSY] = s.busy;
					next_s.rdata[STAT_CONV] = (s.st == ST_CONV);
					next_s.rdata[STAT_SHIFT] = (s.bit_cnt != BITS_DONE);
					next_s.rdata[STAT_RESET_PIN] = s.rst_s;
				end
				OFF_RESULT: next_s.rdata = 32'(s.result);
				default: begin
					next_s.rdata = 32'h0000_0000;
					next_s.rresp = RESP_SLVERR;
				end
			endcase
		end
		next_s.arready = !next_s.rvalid;

		// Reset pin: held high aborts, its release clears result and configuration
		if (s.rst_s) begin
			next_s.st = ST_IDLE;
			next_s.busy = 1'b0;
			next_s.bit_cnt = BITS_DONE;
			next_s.sclk = 1'b0;
			next_s.half_cnt = 4'h0;
			next_s.overrun = 1'b0;
		end
		if (rst_fall) begin
			next_s.result = '0;
			next_s.cfg = CFG_RESET;
			next_s.sh = '0;
		end

		// Pin drive; nothing drives while deselected, so a bus stays shareable
		next_s.dout = '0;
		next_s.doe = '0;
		if (selected && !rst_fall) begin
			unique case (mode)
				MODE_P18: begin
					next_s.dout = coded;
					next_s.doe = '1;
				end
				MODE_P16: begin
					next_s.dout[15:0] = s.ws_s[0] ? {coded[1:0], 14'h0000} : coded[17:2];
					next_s.doe[15:0] = 16'hFFFF;
				end
				MODE_P8: begin
					unique case (s.ws_s)
						2'h0: next_s.dout[7:0] = coded[17:10];
						2'h1: next_s.dout[7:0] = coded[9:2];
						2'h2: next_s.dout[7:0] = {coded[1:0], 6'h00};
						2'h3: next_s.dout[7:0] = 8'h00;
					endcase
					next_s.doe[7:0] = 8'hFF;
				end
				MODE_SER: begin
					if (master_ser) begin
						next_s.dout[PIN_MS_OUT] = s.sh[RES_BITS-1];
						next_s.dout[PIN_MS_CLK] = s.sclk ^ s.ctrl[CTRL_SCLK_INV];
						next_s.dout[PIN_MS_SYNC] = master_active ^ s.ctrl[CTRL_SYNC_INV];
						next_s.doe[PIN_MS_OUT] = 1'b1;
						next_s.doe[PIN_MS_CLK] = 1'b1;
						next_s.doe[PIN_MS_SYNC] = 1'b1;
					end else begin
						next_s.dout[PIN_SS_OUT] = s.sh[RES_BITS-1];
						next_s.dout[PIN_SS_ERR] = next_s.overrun;
						next_s.doe[PIN_SS_OUT] = 1'b1;
						next_s.doe[PIN_SS_ERR] = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= RESET_STATE;
		end else begin
			s <= next_s;
		end
	end

	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rresp = s.rresp;
	assign rdata = s.rdata;
	assign data_out = s.dout;
	assign data_oe = s.doe;
	assign busy = s.busy;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_deselected;
		s.cs_s || s.rd_s || s.rst_s;
	endsequence
	sequence s_underrun;
		conv_done && slave_ser && read_during_conv && s.bit_cnt != BITS_DONE;
	endsequence
	sequence s_overrun_pulse;
		s.overrun ##1 !s.overrun;
	endsequence

	property p_tristate;
		s_deselected |=> data_oe == '0;
	endproperty
	a_tristate: assert property (p_tristate) else $error("outputs driven while deselected");

	property p_reset_abort;
		s.rst_s |=> !busy && s.st == ST_IDLE && data_oe == '0;
	endproperty
	a_reset_abort: assert property (p_reset_abort) else $error("reset pin did not abort");

	property p_reset_clear;
		s.rst_d && !s.rst_s |=> s.result == '0 && s.cfg == '0;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset release did not clear");

	property p_width16;
		selected && !rst_fall && mode == MODE_P16 |=> data_oe == 18'h0FFFF;
	endproperty
	a_width16: assert property (p_width16) else $error("16-bit bus drive wrong");

	property p_straight18;
		selected && !rst_fall && mode == MODE_P18 |=> data_out == $past(s.result) && data_oe == 18'h3FFFF;
	endproperty
	a_straight18: assert property (p_straight18) else $error("18-bit bus not straight binary");

	property p_twos16;
		selected && !rst_fall && mode == MODE_P16 && !s.ctrl[CTRL_CODING] && !s.ws_s[0] |=>
			data_out[15] == !$past(s.result[17]);
	endproperty
	a_twos16: assert property (p_twos16) else $error("coding select ignored");

	property p_cfg_locked;
		!serial && !s.rst_d |=> $stable(s.cfg);
	endproperty
	a_cfg_locked: assert property (p_cfg_locked) else $error("config changed outside serial mode");

	property p_bit_step;
		master_active && s.sclk && s.half_cnt == 4'h0 && !s.rst_s && !conv_done |=> s.bit_cnt == $past(s.bit_cnt) + 5'h01;
	endproperty
	a_bit_step: assert property (p_bit_step) else $error("master bit count did not advance");

	property p_shift_busy;
		s.st == ST_SHIFT |-> busy;
	endproperty
	a_shift_busy: assert property (p_shift_busy) else $error("busy dropped before shift-out done");

	property p_conv_hold;
		s.st == ST_CONV && s.conv_cnt != '0 && !s.rst_s |=> s.st == ST_CONV && busy;
	endproperty
	a_conv_hold: assert property (p_conv_hold) else $error("conversion ended early");

	property p_overrun;
		s_underrun and !s.rst_s |=> s_overrun_pulse;
	endproperty
	a_overrun: assert property (p_overrun) else $error("read overrun not pulsed once");

	property p_slave_gate;
		slave_ser && !selected && !conv_done && !s.rst_s |=> $stable(s.bit_cnt);
	endproperty
	a_slave_gate: assert property (p_slave_gate) else $error("slave shifted while deselected");

	property p_busy_start;
		$rose(busy) |-> $past(start) && $past(s.st == ST_IDLE);
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy rose without a start");
endmodule // arp_readout

// ---- testbench/arp_host_model.sv ----
`timescale 1ns/1ps
module arp_host_model (
	input wire logic aclk,
	input wire logic busy,
	input wire logic [arp_pkg::RES_BITS-1:0] data_out,
	input wire logic [arp_pkg::RES_BITS-1:0] data_oe,
	output logic cs_n_pin,
	output logic rd_n_pin,
	output logic word_select_lo,
	output logic word_select_hi,
	output logic serial_shift_clock,
	output logic [arp_pkg::RES_BITS-1:0] pin_level
);
	import arp_pkg::*;
	// Released pins fall to the board pull-downs, never hold the last value
	assign pin_level = data_oe & data_out;
	initial begin
		cs_n_pin = 1'b1;
		rd_n_pin = 1'b1;
		word_select_lo = 1'b0;
		word_select_hi = 1'b0;
		serial_shift_clock = 1'b0;
	end
	// Selects without waiting on busy; pins get six clocks to pass the device synchronisers
	task automatic sel(input logic on, input logic [1:0] ws);
		@(posedge aclk);
		cs_n_pin <= !on;
		rd_n_pin <= !on;
		{word_select_hi, word_select_lo} <= ws;
		repeat (6) @(posedge aclk);
	endtask
	// Clock moves only while busy is low, so nothing toggles late in a conversion
	task automatic pulse();
		while (busy) @(posedge aclk);
		serial_shift_clock <= 1'b1;
		repeat (4) @(posedge aclk);
		serial_shift_clock <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask
endmodule // arp_host_model

// ---- testbench/tb_adc_result_readout_port.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_adc_result_readout_port;
	import arp_pkg::*;
	localparam logic [17:0] V1 = 18'h2A5C3;
	localparam logic [17:0] V2 = 18'h3C0F1;
	localparam logic [17:0] V3 = 18'h15A3C;
	localparam logic [17:0] V4 = 18'h0F00F;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, busy;
	logic [3:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rdv;
	logic [1:0] bresp, rresp, rsp;
	logic cs_n_pin, rd_n_pin, reset_pin, convert_start_n, ws_lo, ws_hi, sclk;
	logic [17:0] conv_result, data_out, data_oe, lvl;
	int n_errors, cmp_count;

	arp_readout #(.CONV_LEN(100)) uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .cs_n_pin(cs_n_pin),
		.rd_n_pin(rd_n_pin), .reset_pin(reset_pin), .convert_start_n(convert_start_n), .word_select_lo(ws_lo),
		.word_select_hi(ws_hi), .serial_shift_clock(sclk), .conv_result(conv_result), .data_out(data_out),
		.data_oe(data_oe), .busy(busy));
	arp_host_model host (.aclk(aclk), .busy(busy), .data_out(data_out), .data_oe(data_oe), .cs_n_pin(cs_n_pin),
		.rd_n_pin(rd_n_pin), .word_select_lo(ws_lo), .word_select_hi(ws_hi), .serial_shift_clock(sclk),
		.pin_level(lvl));

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic close_out();
		if (n_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// Leaves the start pin high again with the conversion under way
	task automatic kick(input logic [17:0] v);
		@(posedge aclk);
		conv_result <= v;
		convert_start_n <= 1'b0;
		repeat (4) @(posedge aclk);
		convert_start_n <= 1'b1;
	endtask

	task automatic idle();
		while (busy) @(posedge aclk);
	endtask

	task automatic mcap(input logic [17:0] v, input logic [17:0] e, input int per);
		logic [17:0] got;
		logic prev;
		int n, t, last;
		n = 0;
		t = 0;
		last = 0;
		got = 18'h0;
		prev = lvl[PIN_MS_CLK];
		kick(v);
		while (busy) begin
			@(posedge aclk);
			if (lvl[PIN_MS_CLK] && !prev) begin
				got = {got[16:0], lvl[PIN_MS_OUT]};
				`CHK(lvl[PIN_MS_SYNC], 1'b1)
				if (n == 1) `CHK(t - last, per)
				last = t;
				n++;
			end
			prev = lvl[PIN_MS_CLK];
			t++;
		end
		`CHK(n, 18)
		`CHK(got, e)
	endtask

	function automatic logic [7:0] e8(input logic [17:0] v, input int i);
		case (i)
			0: return v[17:10];
			1: return v[9:2];
			default: return {v[1:0], 6'h0};
		endcase
	endfunction

	initial begin
		repeat (50000) @(posedge aclk);
		n_errors++;
		close_out();
	end

	initial begin
		logic [17:0] got;
		n_errors = 0;
		cmp_count = 0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr = 4'h0;
		araddr = 4'h0;
		wdata = 32'h0;
		reset_pin = 1'b0;
		convert_start_n = 1'b1;
		conv_result = 18'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		wr(OFF_STATUS, 32'h1, rsp);
		`CHK(rsp, RESP_SLVERR)
		wr(OFF_CTRL, 32'h0, rsp);
		kick(V1);
		idle();
		host.sel(1'b1, 2'h0);
		`CHK(data_oe, 18'h3FFFF)
		`CHK(data_out, V1)
		wr(OFF_CTRL, 32'h1, rsp);
		host.sel(1'b1, 2'h0);
		`CHK(data_out[15:0], V1[17:2] ^ 16'h8000)
		host.sel(1'b1, 2'h1);
		`CHK(data_out[15:0], {V1[1:0], 14'h0})
		wr(OFF_CTRL, 32'h6, rsp);
		for (int i = 0; i < 3; i++) begin
			host.sel(1'b1, i[1:0]);
			`CHK(data_out[7:0], e8(V1, i))
		end
		host.sel(1'b0, 2'h0);
		`CHK(data_oe, 18'h0)
		wr(OFF_CFG, 32'h1, rsp);
		`CHK(rsp, RESP_SLVERR)
		wr(OFF_CTRL, 32'h83, rsp);
		host.sel(1'b1, 2'h0);
		// Configuration still clear, so the serial result leaves in twos complement
		mcap(V2, V2 ^ 18'h20000, 4);
		wr(OFF_CFG, 32'h1, rsp);
		`CHK(rsp, RESP_OKAY)
		rd(OFF_CFG, rdv, rsp);
		`CHK(rdv, 32'h1)
		`CHK(rsp, RESP_OKAY)
		wr(OFF_CTRL, 32'h43, rsp);
		mcap(V4, V2, 4);
		wr(OFF_CTRL, 32'h33, rsp);
		repeat (6) @(posedge aclk);
		`CHK(lvl[PIN_MS_CLK], 1'b1)
		`CHK(lvl[PIN_MS_SYNC], 1'b1)
		wr(OFF_CTRL, 32'hB, rsp);
		kick(V3);
		idle();
		// Let the freshly loaded first bit reach the pin
		repeat (2) @(posedge aclk);
		for (int i = 0; i < 18; i++) begin
			got = {got[16:0], lvl[PIN_SS_OUT]};
			host.pulse();
		end
		`CHK(got, V3)
		// A second result in read-during mode with nothing clocked out
		wr(OFF_CTRL, 32'h4B, rsp);
		kick(V2);
		idle();
		kick(V4);
		idle();
		`CHK(lvl[PIN_SS_ERR], 1'b1)
		@(posedge aclk);
		`CHK(lvl[PIN_SS_ERR], 1'b0)
		wr(OFF_CTRL, 32'h0, rsp);
		kick(V4);
		wr(OFF_CTRL, 32'h200, rsp);
		idle();
		rd(OFF_RESULT, rdv, rsp);
		`CHK(rdv, {14'h0, V4})
		wr(OFF_CTRL, 32'h0, rsp);
		kick(V1);
		reset_pin <= 1'b1;
		repeat (6) @(posedge aclk);
		`CHK(busy, 1'b0)
		`CHK(data_oe, 18'h0)
		reset_pin <= 1'b0;
		repeat (6) @(posedge aclk);
		rd(OFF_RESULT, rdv, rsp);
		`CHK(rdv, 32'h0)
		rd(OFF_CFG, rdv, rsp);
		`CHK(rdv, 32'h0)
		close_out();
	end
endmodule // tb_adc_result_readout_port
